// ### verilog/ifd_regs.vh
// Purpose: constants for the instruction format decoder
// Assumes: bit 0 is the most significant instruction bit
// Notes: register map for the apb slave lives here too
`ifndef IFD_REGS_VH
`define IFD_REGS_VH

// apb register byte offsets
`define IFD_OFS_INSTR 12'h000
`define IFD_OFS_IADDR 12'h004
`define IFD_OFS_CR 12'h008
`define IFD_OFS_FP_STATUS_CONTROL_REGISTER 12'h00C
`define IFD_OFS_XER 12'h010
`define IFD_OFS_CTR 12'h014
`define IFD_OFS_FIELDS 12'h018
`define IFD_OFS_EXTOP 12'h01C
`define IFD_OFS_TARGET 12'h020
`define IFD_OFS_IMM 12'h024
`define IFD_OFS_STATUS 12'h028
`define IFD_OFS_FPREGS 12'h02C
`define IFD_OFS_DEC 12'h030

// reset value and address alignment mask
`define IFD_RST_WORD 32'h00000000
`define IFD_ADDR_MASK 32'hFFFFFFFC

// field selects (little-endian index = 31 - documented bit)
`define IFD_PRIM_HI 31
`define IFD_PRIM_LO 26
`define IFD_F6_HI 25
`define IFD_F6_LO 21
`define IFD_F11_HI 20
`define IFD_F11_LO 16
`define IFD_F16_HI 15
`define IFD_F16_LO 11
`define IFD_F21_HI 10
`define IFD_F21_LO 6
`define IFD_XO_HI 5
`define IFD_XO_LO 1
`define IFD_EO_HI 10
`define IFD_EO_LO 1
`define IFD_EO9_HI 9
`define IFD_EO9_LO 1
`define IFD_BF_HI 25
`define IFD_BF_LO 23
`define IFD_BFA_HI 20
`define IFD_BFA_LO 18
`define IFD_LI_HI 25
`define IFD_LI_LO 2
`define IFD_BD_HI 15
`define IFD_BD_LO 2
`define IFD_D_HI 15
`define IFD_D_LO 0
`define IFD_AA_BIT 1

// primary opcode of the long-displacement branch
`define IFD_OP_LONG 6'h12

// branch option bits, little-endian within the 5-bit field
`define IFD_BO_NOCOND 4
`define IFD_BO_TRUE 3
`define IFD_BO_NOCTR 2
`define IFD_BO_ZERO 1

// compare source selector
`define IFD_SRC_CR 2'h0
`define IFD_SRC_FP_STATUS_CONTROL_REGISTER 2'h1
`define IFD_SRC_XER 2'h2

`endif

// ### verilog/ifd_field_sel.v
// Purpose: pick one 4-bit field out of a 32-bit register
// Assumes: field 0 is the most significant nibble
// Notes: used for compare target and source fields
`timescale 1ns/1ps

module ifd_field_sel (
   input wire [31:0] reg_word,
   input wire [2:0] sel,
   output reg [3:0] field
);
   // field i is documented bits 4i..4i+3, i.e. nibble 7-i from the bottom
   always @* begin
      field = reg_word[(5'h1C - {sel, 2'h0}) +: 4];
   end
endmodule // ifd_field_sel

// ### verilog/ifd_bit_sel.v
// Purpose: pick one bit of a 32-bit register by a 5-bit index
// Assumes: index 0 is the most significant bit
// Notes: used for branch condition and logical sources
`timescale 1ns/1ps

module ifd_bit_sel (
   input wire [31:0] reg_word,
   input wire [4:0] idx,
   output reg bit_out
);
   // big-endian numbering, so invert the index
   always @* begin
      bit_out = reg_word[~idx];
   end
endmodule // ifd_bit_sel

// ### verilog/ifd_decoder.v
// Purpose: instruction format decoder with apb register access
// Assumes: single clock pclk at 100 MHz, asynchronous active-low reset
// Notes: decode results are registered one cycle after the instruction write
// Notes on behaviour
// [RQ1] every instruction is one aligned 32-bit four-byte word
// [RQ2] low two bits of a supplied instruction address are ignored
// [RQ3] generated instruction addresses have their low two bits zero
// [RQ4] primary opcode is always bits 0 to 5
// [RQ5] xo-form nine-bit extended opcode is bits 22 to 30
// [RQ6] other x-form ten-bit extended opcode is bits 21 to 30
// [RQ7] a-form short extended opcode is bits 26 to 30
// [RQ8] a-form names four floating-point registers plus short opcode
// [RQ9] relative branch target is sign-extended displacement plus instruction address
// [RQ10] absolute branch target is the sign-extended displacement alone
// [RQ11] conditional offset is 14-bit displacement with two zeros, sign-extended
// [RQ12] target selector i picks bits 4i..4i+3 of condition or fp status
// [RQ13] source selector picks a field of condition, fp status or exception register
// [RQ14] condition index picks the condition register bit tested by branches
// [RQ15] first logical source picks one condition register bit
// [RQ16] second logical source picks one condition register bit
// [RQ17] branch options choose counter test, condition test, both, or always
// [RQ18] 16-bit immediate is sign-extended to 32 bits
// [RQ19] target sums wrap modulo 2^32 and low two bits are cleared
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "ifd_regs.vh"

module ifd_decoder (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg [5:0] primary_opcode,
   output reg [31:0] branch_target,
   output reg branch_taken,
   output reg branch_ctr_dec
);
   // ----------------------------------------------------------------
   // software-visible state
   // ----------------------------------------------------------------
   reg [31:0] instr_q;
   reg [31:0] iaddr_q;
   reg [31:0] cr_q;
   reg [31:0] fp_status_control_register_q;
   reg [31:0] xer_q;
   reg [31:0] ctr_q;
   reg [1:0] src_sel_q;
   reg valid_q;
   wire wr_en;
   wire setup_ph;
   assign wr_en = psel & penable & pwrite;
   // setup cycle of a transfer, answered at the next edge
   assign setup_ph = psel & ~penable;

   // ----------------------------------------------------------------
   // field extraction
   // ----------------------------------------------------------------
   wire [5:0] prim_d;
   wire [8:0] nine_bit_extended_opcode;
   wire [9:0] long_extended_opcode;
   wire [4:0] short_extended_opcode;
   wire [4:0] fp_target_reg;
   wire [4:0] fp_source_one;
   wire [4:0] fp_source_two;
   wire [4:0] fp_source_three;
   wire [2:0] compare_target_field_selector;
   wire [2:0] compare_source_field_selector;
   wire [4:0] branch_condition_index;
   wire [4:0] source_one_selector;
   wire [4:0] source_two_selector;
   wire [4:0] branch_options;
   wire absolute_target_flag;
   wire [23:0] long_displacement;
   wire [13:0] cond_branch_displacement;
   wire [15:0] imm16;
   assign prim_d = instr_q[`IFD_PRIM_HI:`IFD_PRIM_LO]; // [RQ4]
   assign nine_bit_extended_opcode = instr_q[`IFD_EO9_HI:`IFD_EO9_LO]; // [RQ5]
   assign long_extended_opcode = instr_q[`IFD_EO_HI:`IFD_EO_LO]; // [RQ6]
   assign short_extended_opcode = instr_q[`IFD_XO_HI:`IFD_XO_LO]; // [RQ7]
   // four fp register numbers of the four-operand form
   assign fp_target_reg = instr_q[`IFD_F6_HI:`IFD_F6_LO]; // [RQ8]
   assign fp_source_one = instr_q[`IFD_F11_HI:`IFD_F11_LO]; // [RQ8]
   assign fp_source_two = instr_q[`IFD_F16_HI:`IFD_F16_LO]; // [RQ8]
   assign fp_source_three = instr_q[`IFD_F21_HI:`IFD_F21_LO]; // [RQ8]
   assign compare_target_field_selector = instr_q[`IFD_BF_HI:`IFD_BF_LO];
   assign compare_source_field_selector = instr_q[`IFD_BFA_HI:`IFD_BFA_LO];
   assign branch_options = instr_q[`IFD_F6_HI:`IFD_F6_LO];
   assign branch_condition_index = instr_q[`IFD_F11_HI:`IFD_F11_LO];
   assign source_one_selector = instr_q[`IFD_F11_HI:`IFD_F11_LO];
   assign source_two_selector = instr_q[`IFD_F16_HI:`IFD_F16_LO];
   assign absolute_target_flag = instr_q[`IFD_AA_BIT];
   assign long_displacement = instr_q[`IFD_LI_HI:`IFD_LI_LO];
   assign cond_branch_displacement = instr_q[`IFD_BD_HI:`IFD_BD_LO];
   assign imm16 = instr_q[`IFD_D_HI:`IFD_D_LO];

   // ----------------------------------------------------------------
   // sign extension and target arithmetic
   // ----------------------------------------------------------------
   wire [31:0] li_ext;
   wire [31:0] bd_ext;
   wire [31:0] imm_ext;
   wire [31:0] iaddr_al;
   wire long_form;
   assign li_ext = {{6{long_displacement[23]}}, long_displacement, 2'h0};
   assign bd_ext = {{16{cond_branch_displacement[13]}}, cond_branch_displacement, 2'h0}; // [RQ11]
   assign long_form = (prim_d == `IFD_OP_LONG);
   assign imm_ext = {{16{imm16[15]}}, imm16}; // [RQ18]
   assign iaddr_al = iaddr_q & `IFD_ADDR_MASK; // [RQ2]

   reg [31:0] disp_sel;
   reg [31:0] tgt_sum;
   // opcode 18 is the long form; everything else uses the 14-bit form
   always @* begin
      disp_sel = long_form ? li_ext : bd_ext;
      // 32-bit add wraps naturally, carry out discarded
      tgt_sum = absolute_target_flag ? disp_sel : (disp_sel + iaddr_al); // [RQ9] [RQ10] [RQ19]
   end

   // ----------------------------------------------------------------
   // condition selection
   // ----------------------------------------------------------------
   wire cond_bit;
   wire src_one_bit;
   wire src_two_bit;
   wire [3:0] tgt_cr_field;
   wire [3:0] tgt_fp_field;
   wire [3:0] src_cr_field;
   wire [3:0] src_fp_field;
   wire [3:0] src_xer_field;
   reg [3:0] src_field;

   ifd_bit_sel u_cond ( // [RQ14]
      .reg_word(cr_q),
      .idx(branch_condition_index),
      .bit_out(cond_bit)
   );
   ifd_bit_sel u_src1 ( // [RQ15]
      .reg_word(cr_q),
      .idx(source_one_selector),
      .bit_out(src_one_bit)
   );
   ifd_bit_sel u_src2 ( // [RQ16]
      .reg_word(cr_q),
      .idx(source_two_selector),
      .bit_out(src_two_bit)
   );
   ifd_field_sel u_tcr ( // [RQ12]
      .reg_word(cr_q),
      .sel(compare_target_field_selector),
      .field(tgt_cr_field)
   );
   ifd_field_sel u_tfp ( // [RQ12]
      .reg_word(fp_status_control_register_q),
      .sel(compare_target_field_selector),
      .field(tgt_fp_field)
   );
   ifd_field_sel u_scr ( // [RQ13]
      .reg_word(cr_q),
      .sel(compare_source_field_selector),
      .field(src_cr_field)
   );
   ifd_field_sel u_sfp ( // [RQ13]
      .reg_word(fp_status_control_register_q),
      .sel(compare_source_field_selector),
      .field(src_fp_field)
   );
   ifd_field_sel u_sxe ( // [RQ13]
      .reg_word(xer_q),
      .sel(compare_source_field_selector),
      .field(src_xer_field)
   );

   // software picks which register feeds the source field
   always @* begin
      case (src_sel_q)
         `IFD_SRC_FP_STATUS_CONTROL_REGISTER: src_field = src_fp_field; // [RQ13]
         `IFD_SRC_XER: src_field = src_xer_field; // [RQ13]
         default: src_field = src_cr_field;
      endcase
   end

   // ----------------------------------------------------------------
   // branch option evaluation
   // ----------------------------------------------------------------
   reg [31:0] ctr_next;
   reg ctr_ok;
   reg cond_ok;
   reg take;
   always @* begin
      ctr_next = ctr_q - 32'h00000001;
      // counter test passes when skipped or when result matches zero/nonzero choice
      ctr_ok = branch_options[`IFD_BO_NOCTR] |
               ((ctr_next == 32'h00000000) == branch_options[`IFD_BO_ZERO]); // [RQ17]
      cond_ok = branch_options[`IFD_BO_NOCOND] | (cond_bit == branch_options[`IFD_BO_TRUE]); // [RQ17]
      take = ctr_ok & cond_ok; // [RQ17]
   end

   // ----------------------------------------------------------------
   // read words, assembled once for the read mux
   // ----------------------------------------------------------------
   wire [31:0] fields_word;
   wire [31:0] extop_word;
   wire [31:0] status_word;
   wire [31:0] fpregs_word;
   wire [31:0] target_word;
   // only the low four option bits fit; the top one stays in the instruction
   assign fields_word = {branch_options[3:0], branch_condition_index, source_two_selector,
                         compare_target_field_selector, compare_source_field_selector,
                         tgt_cr_field, tgt_fp_field, src_field};
   // opcode and all three extended-opcode views side by side
   assign extop_word = {2'h0, prim_d, short_extended_opcode, nine_bit_extended_opcode,
                        long_extended_opcode};
   // live decode flags above the source select
   assign status_word = {24'h000000, valid_q, take, src_one_bit, src_two_bit,
                         cond_bit, absolute_target_flag, src_sel_q};
   // four fp register numbers, target first
   assign fpregs_word = {12'h000, fp_target_reg, fp_source_one, fp_source_two,
                         fp_source_three}; // [RQ8]
   // fetch address: low bits forced clear whatever the sum
   assign target_word = tgt_sum & `IFD_ADDR_MASK; // [RQ3] [RQ19]

   // ----------------------------------------------------------------
   // apb writes and decoded outputs
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_q <= `IFD_RST_WORD;
         iaddr_q <= `IFD_RST_WORD;
         cr_q <= `IFD_RST_WORD;
         fp_status_control_register_q <= `IFD_RST_WORD;
         xer_q <= `IFD_RST_WORD;
         ctr_q <= `IFD_RST_WORD;
         src_sel_q <= `IFD_SRC_CR;
         valid_q <= 1'b0;
      end else begin
         valid_q <= wr_en && (paddr == `IFD_OFS_INSTR);
         if (wr_en) begin
            case (paddr)
               `IFD_OFS_INSTR: instr_q <= pwdata; // [RQ1]
               `IFD_OFS_IADDR: iaddr_q <= pwdata;
               `IFD_OFS_CR: cr_q <= pwdata;
               `IFD_OFS_FP_STATUS_CONTROL_REGISTER: fp_status_control_register_q <= pwdata;
               `IFD_OFS_XER: xer_q <= pwdata;
               `IFD_OFS_CTR: ctr_q <= pwdata;
               `IFD_OFS_STATUS: src_sel_q <= pwdata[1:0];
               default: ;
            endcase
         end
      end
   end

   // registered decode outputs, refreshed every cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_opcode <= 6'h00;
         branch_target <= `IFD_RST_WORD;
         branch_taken <= 1'b0;
         branch_ctr_dec <= 1'b0;
      end else begin
         primary_opcode <= prim_d; // [RQ4]
         branch_target <= target_word; // [RQ3] [RQ19]
         branch_taken <= take;
         branch_ctr_dec <= ~branch_options[`IFD_BO_NOCTR]; // [RQ17]
      end
   end

   // ----------------------------------------------------------------
   // apb read path, zero wait states
   // ----------------------------------------------------------------
   reg [31:0] rd_d;
   reg err_d;
   always @* begin
      err_d = 1'b0;
      case (paddr)
         `IFD_OFS_INSTR: rd_d = instr_q;
         `IFD_OFS_IADDR: rd_d = iaddr_q;
         `IFD_OFS_CR: rd_d = cr_q;
         `IFD_OFS_FP_STATUS_CONTROL_REGISTER: rd_d = fp_status_control_register_q;
         `IFD_OFS_XER: rd_d = xer_q;
         `IFD_OFS_CTR: rd_d = ctr_q;
         `IFD_OFS_FIELDS: rd_d = fields_word;
         `IFD_OFS_EXTOP: rd_d = extop_word;
         `IFD_OFS_TARGET: rd_d = target_word; // [RQ3]
         `IFD_OFS_IMM: rd_d = imm_ext; // [RQ18]
         `IFD_OFS_STATUS: rd_d = status_word;
         `IFD_OFS_FPREGS: rd_d = fpregs_word; // [RQ8]
         `IFD_OFS_DEC: rd_d = ctr_next;
         default: begin
            rd_d = 32'h00000000;
            err_d = 1'b1;
         end
      endcase
   end

   // pready high in the access phase only, so every transfer is two cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_ph;
         pslverr <= setup_ph & err_d;
         prdata <= (setup_ph & ~pwrite) ? rd_d : 32'h00000000;
      end
   end

endmodule // ifd_decoder

// ### tb/ifd_decoder_props.sv
// Purpose: port-level checks for the instruction decoder
// Assumes: zero-wait apb slave, decode settled three edges after a write
// Notes: tracks the last instruction word written over the bus
`timescale 1ns/1ps
module ifd_decoder_props (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [5:0] primary_opcode,
   input wire [31:0] branch_target,
   input wire branch_taken,
   input wire branch_ctr_dec
);
   // ----------------------------------------
   // last instruction word and its age
   // ----------------------------------------
   reg [31:0] word_q;
   reg [1:0] age_q;
   wire wr_instr = psel && penable && pwrite && pready && paddr == 12'h000;
   wire settled = age_q == 2'h3;
   // age saturates, so later reads keep the checks armed
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q <= 32'h00000000;
         age_q <= 2'h0;
      end else if (wr_instr) begin
         word_q <= pwdata;
         age_q <= 2'h0;
      end else if (!settled) begin
         age_q <= age_q + 2'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // bus and decode relations
   // ----------------------------------------
   ready_follow_a: assert property (psel && !penable |=> pready) else $error("no answer to setup");
   ready_single_a: assert property (pready |=> !pready) else $error("pready held two cycles");
   ready_phase_a: assert property (pready |-> psel && penable) else $error("pready outside access");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000) else $error("prdata not idle");
   unmapped_err_a: assert property (psel && !penable && paddr > 12'h030 |=> pslverr) else $error("no error");
   target_align_a: assert property (branch_target[1:0] == 2'h0) else $error("target unaligned");
   opcode_track_a: assert property (settled |-> primary_opcode == word_q[31:26]) else $error("opcode");
   abs_target_a: assert property (settled && word_q[1] && word_q[31:26] == 6'h12
      |-> branch_target == {{6{word_q[25]}}, word_q[25:2], 2'h0}) else $error("absolute target");
   always_take_a: assert property (settled && word_q[31:26] == 6'h10 && word_q[25] && word_q[23]
      |-> branch_taken) else $error("branch always not taken");
   ctr_dec_a: assert property (settled && word_q[31:26] == 6'h10
      |-> branch_ctr_dec == !word_q[23]) else $error("counter decrement flag");
endmodule // ifd_decoder_props
bind ifd_decoder ifd_decoder_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .primary_opcode(primary_opcode), .branch_target(branch_target), .branch_taken(branch_taken),
   .branch_ctr_dec(branch_ctr_dec));

// ### tb/ifd_apb_host.sv
// Purpose: fetch-side apb master feeding instruction words
// Assumes: one 32-bit word per transfer
// Notes: waits on pready with no cycle count of its own
`timescale 1ns/1ps
module ifd_apb_host (
   input wire pclk,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   output reg psel,
   output reg penable,
   output reg pwrite,
   output reg [11:0] paddr,
   output reg [31:0] pwdata
);
   // idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   // one whole word per transfer, request held until pready
   task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (!pready) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines flip so stale values never look valid
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // ifd_apb_host

// ### tb/tb.sv
// Purpose: self-checking bench for the instruction decoder
// Assumes: decode outputs settle within four edges of a write
// Notes: expectations built from field positions, not from the design
`timescale 1ns/1ps
`include "ifd_regs.vh"
module tb;
   reg pclk, presetn, er;
   reg [31:0] rd;
   wire psel, penable, pwrite, pready, pslverr, branch_taken, branch_ctr_dec;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata, branch_target;
   wire [5:0] primary_opcode;
   integer err_total = 0, tests_run = 0, i;
   localparam [31:0] CRV = 32'h13579BDF, FPV = 32'h2468ACE0, XRV = 32'hFEDCBA98, W = 32'h7D6AB5B7;
   // {options, index, taken, decrement} with condition bit 0 set and counter 1
   localparam [95:0] BO_TAB = {12'b10100_00000_10, 12'b01100_00000_10, 12'b00100_00000_00,
      12'b00100_00001_10, 12'b10000_00000_01, 12'b10010_00000_11, 12'b01010_00000_11, 12'b00000_00000_01};
   ifd_decoder i_ifd_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .primary_opcode(primary_opcode), .branch_target(branch_target), .branch_taken(branch_taken),
      .branch_ctr_dec(branch_ctr_dec));
   ifd_apb_host i_ifd_apb_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      i_ifd_apb_host.xfer(1'b1, a, d, rd, er);
   endtask
   task rdr(input [11:0] a);
      i_ifd_apb_host.xfer(1'b0, a, 32'h00000000, rd, er);
   endtask
   // instruction write, then let the decode land
   task ld(input [31:0] w);
      wr(`IFD_OFS_INSTR, w);
      repeat (4) @(posedge pclk);
   endtask
   task br(input [31:0] ia, input [31:0] w, input [31:0] e);
      wr(`IFD_OFS_IADDR, ia);
      ld(w);
      chk("target", branch_target, e);
      rdr(`IFD_OFS_TARGET);
      chk("target reg", rd, e);
   endtask
   task stop_test;
      if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_map;
      rdr(`IFD_OFS_CR);
      chk("cr reset", rd, 32'h00000000);
      rdr(12'h040);
      chk("unmapped err", er, 1'b1);
      chk("unmapped data", rd, 32'h00000000);
   endtask
   task t_fields;
      ld(W);
      chk("opcode", primary_opcode, W[31:26]);
      rdr(`IFD_OFS_EXTOP);
      chk("extop", rd, {2'h0, W[31:26], W[5:1], W[9:1], W[10:1]});
      rdr(`IFD_OFS_FPREGS);
      chk("fpregs", rd, {12'h000, W[25:6]});
      rdr(`IFD_OFS_IMM);
      chk("imm", rd, {{16{W[15]}}, W[15:0]});
   endtask
   task t_branch;
      br(32'h00001003, 32'h4000FFFD, 32'h00000FFC);
      br(32'h00001003, 32'h4000FFFF, 32'hFFFFFFFC);
      br(32'hFFFFFFF2, 32'h48000020, 32'h00000010);
      br(32'h00000000, 32'h4BFFFFFE, 32'hFFFFFFFC);
   endtask
   task t_options;
      wr(`IFD_OFS_CR, 32'h80000000);
      wr(`IFD_OFS_CTR, 32'h00000001);
      for (i = 7; i >= 0; i = i - 1) begin
         ld({6'h10, BO_TAB[i*12+2 +: 10], 16'h0000});
         chk("taken", branch_taken, BO_TAB[i*12+1]);
         chk("ctr dec", branch_ctr_dec, BO_TAB[i*12]);
      end
      rdr(`IFD_OFS_DEC);
      chk("ctr minus one", rd, 32'h00000000);
   endtask
   // target field 2, source field 5, bit sources 20 and 3
   task t_select;
      reg [3:0] src;
      wr(`IFD_OFS_CR, CRV);
      wr(`IFD_OFS_FP_STATUS_CONTROL_REGISTER, FPV);
      wr(`IFD_OFS_XER, XRV);
      ld({6'h13, 3'h2, 2'h0, 3'h5, 2'h0, 5'h03, 11'h000});
      for (i = 0; i < 3; i = i + 1) begin
         wr(`IFD_OFS_STATUS, i);
         src = (i == 0) ? CRV[11:8] : (i == 1) ? FPV[11:8] : XRV[11:8];
         rdr(`IFD_OFS_FIELDS);
         chk("fields", rd[11:0], {CRV[23:20], FPV[23:20], src});
         rdr(`IFD_OFS_STATUS);
         chk("bits", {rd[5:3], rd[1:0]}, {CRV[11], CRV[28], CRV[11], i[1:0]});
      end
   endtask
   // ----------------------------------------
   // clock, reset, sequence, watchdog
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_map;
      t_fields;
      t_branch;
      t_options;
      t_select;
      stop_test;
   end
   // whole run needs well under 1500 cycles
   initial begin
      #50000;
      err_total = err_total + 1;
      stop_test;
   end
endmodule // tb
